// file: instr_timing_pkg.sv
/*
  constants and enumerations for the instruction timing and flag block.
  assumes one instruction cycle of four system clocks.
*/
package instr_timing_pkg;

  localparam int unsigned CLKS_PER_CYCLE = 4;
  localparam logic [1:0]  PHASE_LAST     = 2'h3;
  localparam logic [1:0]  PHASE_RESET    = 2'h0;
  localparam logic [7:0]  PC_LOW_ADDR    = 8'h02;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [7:0]  BYTE_ONES      = 8'hff;
  localparam logic [1:0]  BASE_ONE       = 2'h1;
  localparam logic [1:0]  BASE_TWO       = 2'h2;

  typedef enum logic [5:0] {
    OP_NOP      = 6'h00,
    OP_INCA     = 6'h01,
    OP_INC      = 6'h02,
    OP_DECA     = 6'h03,
    OP_DEC      = 6'h04,
    OP_RRA      = 6'h05,
    OP_RR       = 6'h06,
    OP_RRCA     = 6'h07,
    OP_RRC      = 6'h08,
    OP_RLA      = 6'h09,
    OP_RL       = 6'h0a,
    OP_RLCA     = 6'h0b,
    OP_RLC      = 6'h0c,
    OP_MOV_AM   = 6'h0d,
    OP_MOV_MA   = 6'h0e,
    OP_MOV_AX   = 6'h0f,
    OP_BCLR     = 6'h10,
    OP_BSET     = 6'h11,
    OP_JMP      = 6'h12,
    OP_SZ       = 6'h13,
    OP_SKZ_MOVE = 6'h14,
    OP_SZB      = 6'h15,
    OP_SNZB     = 6'h16,
    OP_INC_SKZ  = 6'h17,
    OP_DEC_SKZ  = 6'h18,
    OP_SIZA     = 6'h19,
    OP_SDZA     = 6'h1a,
    OP_CALL     = 6'h1b,
    OP_RET      = 6'h1c,
    OP_RETAX    = 6'h1d,
    OP_IRET     = 6'h1e,
    OP_TRD_CUR  = 6'h1f,
    OP_TRD_LAST = 6'h20,
    OP_CLR      = 6'h21,
    OP_SET      = 6'h22,
    OP_WDT_CLR  = 6'h23,
    OP_WDT_PRE1 = 6'h24,
    OP_WDT_PRE2 = 6'h25,
    OP_SWAP     = 6'h26,
    OP_SWAP_W   = 6'h27,
    OP_HALT     = 6'h28
  } opcode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_HALT = 2'b10
  } state_t;

endpackage : instr_timing_pkg

// file: instr_timing.sv
/*
  instruction timing, flag effects and datapath results for the
  increment, rotate, move, bit, branch, table read and misc groups.
  assumes the fetch unit holds the next instruction while busy is high,
  that table data is valid when instr_valid is given, and that
  wdt_clear_ok tells whether a preclear completes the watchdog clear.
*/
`timescale 1ns/1ns
`default_nettype none

module instr_timing
  import instr_timing_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        instr_valid,
  input  wire logic [5:0]  instr_op,
  input  wire logic [7:0]  mem_addr,
  input  wire logic [2:0]  bit_sel,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [7:0]  imm_data,
  input  wire logic [15:0] table_word,
  input  wire logic        wdt_clear_ok,
  input  wire logic        wake_up,
  output logic             busy,
  output logic             stall_req,
  output logic             skip_next,
  output logic             table_last_page,
  output logic             mem_we,
  output logic [7:0]       mem_wdata,
  output logic [7:0]       working_register,
  output logic [7:0]       table_high_byte,
  output logic             zero_flag,
  output logic             carry_flag,
  output logic             watchdog_timeout_flag,
  output logic             power_down_flag,
  output logic             wdt_reset,
  output logic             halted
);

  state_t     state_q;
  logic [1:0] phase_q;
  logic [1:0] cycles_left_q;
  opcode_t    op;
  logic [7:0] res;
  logic       to_mem;
  logic       to_wreg;
  logic       skip;
  logic       upd_z;
  logic       upd_c;
  logic       new_c;
  logic [1:0] base;
  logic [1:0] total;

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == BYTE_ZERO);
  endfunction : is_zero

  assign op = opcode_t'(instr_op);

  always_comb begin
    res    = mem_rdata;
    to_mem = 1'b0;
    to_wreg = 1'b0;
    skip   = 1'b0;
    upd_z  = 1'b0;
    upd_c  = 1'b0;
    new_c  = carry_flag;
    base   = BASE_ONE;
    unique case (op)
      OP_INCA, OP_INC: begin
        res = mem_rdata + 8'h01;
        upd_z = 1'b1;
        to_wreg = (op == OP_INCA);
        to_mem = (op == OP_INC);
      end
      OP_DECA, OP_DEC: begin
        res = mem_rdata - 8'h01;
        upd_z = 1'b1;
        to_wreg = (op == OP_DECA);
        to_mem = (op == OP_DEC);
      end
      OP_RRA, OP_RR: begin
        res = {mem_rdata[0], mem_rdata[7:1]};
        to_wreg = (op == OP_RRA);
        to_mem = (op == OP_RR);
      end
      OP_RLA, OP_RL: begin
        res = {mem_rdata[6:0], mem_rdata[7]};
        to_wreg = (op == OP_RLA);
        to_mem = (op == OP_RL);
      end
      OP_RRCA, OP_RRC: begin
        res = {carry_flag, mem_rdata[7:1]};
        new_c = mem_rdata[0];
        upd_c = 1'b1;
        to_wreg = (op == OP_RRCA);
        to_mem = (op == OP_RRC);
      end
      OP_RLCA, OP_RLC: begin
        res = {mem_rdata[6:0], carry_flag};
        new_c = mem_rdata[7];
        upd_c = 1'b1;
        to_wreg = (op == OP_RLCA);
        to_mem = (op == OP_RLC);
      end
      OP_MOV_AM: to_wreg = 1'b1;
      OP_MOV_MA: begin
        res = working_register;
        to_mem = 1'b1;
      end
      OP_MOV_AX, OP_RETAX: begin
        res = imm_data;
        to_wreg = 1'b1;
        base = (op == OP_RETAX) ? BASE_TWO : BASE_ONE;
      end
      OP_BCLR, OP_BSET: begin
        res = mem_rdata;
        res[bit_sel] = (op == OP_BSET);
        to_mem = 1'b1;
      end
      OP_CLR: begin
        res = BYTE_ZERO;
        to_mem = 1'b1;
      end
      OP_SET: begin
        res = BYTE_ONES;
        to_mem = 1'b1;
      end
      OP_SZ: skip = is_zero(mem_rdata);
      OP_SKZ_MOVE: begin
        to_wreg = 1'b1;
        skip = is_zero(mem_rdata);
      end
      OP_SZB: skip = ~mem_rdata[bit_sel];
      OP_SNZB: skip = mem_rdata[bit_sel];
      OP_INC_SKZ, OP_SIZA: begin
        res = mem_rdata + 8'h01;
        skip = is_zero(res);
        to_mem = (op == OP_INC_SKZ);
        to_wreg = (op == OP_SIZA);
      end
      OP_DEC_SKZ, OP_SDZA: begin
        res = mem_rdata - 8'h01;
        skip = is_zero(res);
        to_mem = (op == OP_DEC_SKZ);
        to_wreg = (op == OP_SDZA);
      end
      OP_JMP, OP_CALL, OP_RET, OP_IRET: base = BASE_TWO;
      OP_TRD_CUR, OP_TRD_LAST: begin
        res = table_word[7:0];
        to_mem = 1'b1;
        base = BASE_TWO;
      end
      OP_SWAP, OP_SWAP_W: begin
        res = {mem_rdata[3:0], mem_rdata[7:4]};
        to_mem = (op == OP_SWAP);
        to_wreg = (op == OP_SWAP_W);
      end
      default: ;
    endcase
  end

  // penalties add to the base count
  always_comb begin
    total = base + {1'b0, to_mem && (mem_addr == PC_LOW_ADDR)} + {1'b0, skip};
  end

  logic start;
  assign start = instr_valid && (state_q == ST_IDLE);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q       <= ST_IDLE;
      phase_q       <= PHASE_RESET;
      cycles_left_q <= 2'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (instr_valid) begin
            phase_q       <= PHASE_RESET;
            cycles_left_q <= total;
            state_q       <= (op == OP_HALT) ? ST_HALT : ST_EXEC;
          end
        end
        ST_EXEC: begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == PHASE_LAST) begin
            cycles_left_q <= cycles_left_q - 2'h1;
            if (cycles_left_q == 2'h1) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_HALT: begin
          if (wake_up) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy   <= 1'b0;
      halted <= 1'b0;
    end else begin
      busy   <= start || ((state_q == ST_EXEC) &&
                !((phase_q == PHASE_LAST) && (cycles_left_q == 2'h1)));
      halted <= (start && (op == OP_HALT)) ||
                ((state_q == ST_HALT) && !wake_up);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stall_req       <= 1'b0;
      skip_next       <= 1'b0;
      table_last_page <= 1'b0;
      mem_we          <= 1'b0;
      mem_wdata       <= BYTE_ZERO;
    end else begin
      stall_req       <= start && (total > base);
      skip_next       <= start && skip;
      table_last_page <= start && (op == OP_TRD_LAST);
      mem_we          <= start && to_mem;
      mem_wdata       <= start ? res : mem_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      working_register <= BYTE_ZERO;
      table_high_byte  <= BYTE_ZERO;
      zero_flag        <= 1'b0;
      carry_flag       <= 1'b0;
    end else if (start) begin
      if (to_wreg) working_register <= res;
      if (op == OP_TRD_CUR || op == OP_TRD_LAST) begin
        table_high_byte <= table_word[15:8];
      end
      if (upd_z) zero_flag <= is_zero(res);
      if (upd_c) carry_flag <= new_c;
    end
  end

  logic wdt_hit;
  assign wdt_hit = start && ((op == OP_WDT_CLR) ||
                   ((op == OP_WDT_PRE1 || op == OP_WDT_PRE2) && wdt_clear_ok));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_timeout_flag <= 1'b0;
      power_down_flag       <= 1'b0;
      wdt_reset             <= 1'b0;
    end else begin
      wdt_reset <= wdt_hit || (start && op == OP_HALT);
      if (start && op == OP_HALT) begin
        power_down_flag       <= 1'b1;
        watchdog_timeout_flag <= 1'b0;
      end else if (wdt_hit) begin
        power_down_flag       <= 1'b0;
        watchdog_timeout_flag <= 1'b0;
      end
    end
  end

  stall_timing_a: assert property (@(posedge clk) disable iff (!nrst)
    stall_req |-> busy [*8]) else $error("stall shorter than two cycles");
  jump_two_a: assert property (@(posedge clk) disable iff (!nrst)
    (start && op == OP_JMP) |=> busy [*8] ##1 !busy) else $error("jump not two cycles");
  skip_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    skip_next |-> stall_req) else $error("skip without stall");
  pc_low_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (start && to_mem && mem_addr == PC_LOW_ADDR) |=> stall_req && mem_we)
    else $error("program_counter_low write without stall");
  halt_flags_a: assert property (@(posedge clk) disable iff (!nrst)
    (start && op == OP_HALT) |=> power_down_flag && !watchdog_timeout_flag && halted)
    else $error("halt flags wrong");
  wdt_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (start && op == OP_WDT_CLR) |=> !power_down_flag && !watchdog_timeout_flag && wdt_reset)
    else $error("watchdog clear flags wrong");
  preclear_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (start && (op == OP_WDT_PRE1 || op == OP_WDT_PRE2) && !wdt_clear_ok) |=>
    $stable(power_down_flag) && $stable(watchdog_timeout_flag) && !wdt_reset)
    else $error("preclear changed flags");
  wreg_form_a: assert property (@(posedge clk) disable iff (!nrst)
    (start && (op == OP_SIZA || op == OP_SWAP_W || op == OP_INCA)) |=> !mem_we)
    else $error("working form wrote memory");
  nostall_a: assert property (@(posedge clk) disable iff (!nrst)
    (start && op == OP_SWAP_W) |=> !stall_req) else $error("swap form stalled");

  skip_cov: cover property (@(posedge clk) disable iff (!nrst) skip_next);
  halt_cov: cover property (@(posedge clk) disable iff (!nrst) start && op == OP_HALT);
  table_cov: cover property (@(posedge clk) disable iff (!nrst) start && op == OP_TRD_LAST);

endmodule : instr_timing

`default_nettype wire

// file: mcu_instruction_timing_tb_top.sv
/*
  self-checking bench for instr_timing: a driver queues the expected timing and
  results of each instruction other than halt, a monitor compares them when busy falls.
  assumes instr_timing_pkg and instr_timing are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module mcu_instruction_timing_tb_top;
  import instr_timing_pkg::*;
  typedef struct {
    logic [31:0] len;
    logic [8:0]  flg;
    logic [7:0]  wd;
    logic [7:0]  wrk;
    logic [7:0]  th;
  } note_t;
  logic        clk = 1'b0, nrst = 1'b0, instr_valid = 1'b0, wdt_clear_ok = 1'b0, wake_up = 1'b0;
  logic [5:0]  instr_op = 6'h00;
  logic [7:0]  mem_addr = 8'h00, mem_rdata = 8'h00, imm_data = 8'h00;
  logic [2:0]  bit_sel = 3'h0;
  logic [15:0] table_word = 16'h0000;
  logic        busy, stall_req, skip_next, table_last_page, mem_we, zero_flag, carry_flag;
  logic        watchdog_timeout_flag, power_down_flag, wdt_reset, halted;
  logic [7:0]  mem_wdata, working_register, table_high_byte;
  logic [7:0]  e_wrk = 8'h00, e_th = 8'h00, seed = 8'h09, wcap = 8'h00;
  logic        e_z = 1'b0, e_c = 1'b0, e_pd = 1'b0, bprev = 1'b0;
  logic [8:0]  pul = 9'h000, fl = 9'h000;
  logic [31:0] cnt = 32'h0000_0000;
  int          err_count = 0, samples_checked = 0;
  note_t       q[$];
  note_t       mn;
  opcode_t     pl[$] = '{OP_INC, OP_RRC, OP_MOV_MA, OP_BSET, OP_CLR, OP_SWAP, OP_TRD_LAST,
                         OP_INCA, OP_SWAP_W};

  instr_timing instr_timing_inst (
    .clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr_op(instr_op),
    .mem_addr(mem_addr), .bit_sel(bit_sel), .mem_rdata(mem_rdata), .imm_data(imm_data),
    .table_word(table_word), .wdt_clear_ok(wdt_clear_ok), .wake_up(wake_up), .busy(busy),
    .stall_req(stall_req), .skip_next(skip_next), .table_last_page(table_last_page),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .working_register(working_register),
    .table_high_byte(table_high_byte), .zero_flag(zero_flag), .carry_flag(carry_flag),
    .watchdog_timeout_flag(watchdog_timeout_flag), .power_down_flag(power_down_flag),
    .wdt_reset(wdt_reset), .halted(halted));

  always #4 clk = ~clk;

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  // reference behaviour; updates the expected register state as it goes
  function automatic note_t model(input opcode_t op, input logic [7:0] a, input logic [7:0] m,
                                  input logic [2:0] b, input logic ok);
    note_t n;
    logic [7:0] r, inc, dec;
    logic skp, we, tlp, wr, pc;
    int base;
    inc = m + 8'h01;
    dec = m - 8'h01;
    r = 8'h00;
    skp = 1'b0;
    tlp = 1'b0;
    wr = 1'b0;
    base = 1;
    case (op)
      OP_INCA, OP_INC: begin r = inc; e_z = (inc == 8'h00); end
      OP_DECA, OP_DEC: begin r = dec; e_z = (dec == 8'h00); end
      OP_RRA, OP_RR: r = {m[0], m[7:1]};
      OP_RRCA, OP_RRC: begin r = {e_c, m[7:1]}; e_c = m[0]; end
      OP_RLA, OP_RL: r = {m[6:0], m[7]};
      OP_RLCA, OP_RLC: begin r = {m[6:0], e_c}; e_c = m[7]; end
      OP_MOV_AM, OP_SKZ_MOVE: r = m;
      OP_MOV_MA: r = e_wrk;
      OP_MOV_AX: r = m ^ 8'ha5;
      OP_RETAX: begin r = m ^ 8'ha5; base = 2; end
      OP_BCLR: r = m & ~(8'h01 << b);
      OP_BSET: r = m | (8'h01 << b);
      OP_INC_SKZ, OP_SIZA: r = inc;
      OP_DEC_SKZ, OP_SDZA: r = dec;
      OP_TRD_CUR, OP_TRD_LAST: begin r = ~m; e_th = m; base = 2; tlp = (op == OP_TRD_LAST); end
      OP_SET: r = BYTE_ONES;
      OP_WDT_CLR, OP_WDT_PRE1, OP_WDT_PRE2: if (op == OP_WDT_CLR || ok) begin e_pd = 1'b0; wr = 1'b1; end
      OP_SWAP, OP_SWAP_W: r = {m[3:0], m[7:4]};
      OP_JMP, OP_CALL, OP_RET, OP_IRET: base = 2;
      default: ;
    endcase
    case (op)
      OP_SZ, OP_SKZ_MOVE: skp = (m == 8'h00);
      OP_SZB: skp = !m[b];
      OP_SNZB: skp = m[b];
      OP_INC_SKZ, OP_SIZA: skp = (inc == 8'h00);
      OP_DEC_SKZ, OP_SDZA: skp = (dec == 8'h00);
      default: ;
    endcase
    we = op inside {OP_INC, OP_DEC, OP_RR, OP_RRC, OP_RL, OP_RLC, OP_MOV_MA, OP_BCLR, OP_BSET,
                    OP_INC_SKZ, OP_DEC_SKZ, OP_TRD_CUR, OP_TRD_LAST, OP_CLR, OP_SET, OP_SWAP};
    if (op inside {OP_INCA, OP_DECA, OP_RRA, OP_RRCA, OP_RLA, OP_RLCA, OP_MOV_AM, OP_MOV_AX,
                   OP_SKZ_MOVE, OP_SIZA, OP_SDZA, OP_RETAX, OP_SWAP_W}) e_wrk = r;
    pc = we && (a == PC_LOW_ADDR);
    n.len = 32'(CLKS_PER_CYCLE * (base + int'(pc) + int'(skp)));
    n.flg = {skp, pc | skp, we, tlp, wr, e_z, e_c, e_pd, 1'b0};
    n.wd = we ? r : 8'h00;
    n.wrk = e_wrk;
    n.th = e_th;
    return n;
  endfunction : model

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // sel 0 waits on busy, sel 1 on halted
  task automatic wait_sig(input int sel, input logic v);
    for (int i = 0; i < 80; i++) begin
      @(posedge clk);
      #1;
      if ((sel == 0 ? busy : halted) === v) return;
    end
    err_count++;
    $display("unexpected wait limit on signal %0d", sel);
    stop_test();
  endtask : wait_sig

  task automatic run(input opcode_t op, input logic [7:0] a, input logic [7:0] m,
                     input logic [2:0] b, input logic ok);
    q.push_back(model(op, a, m, b, ok));
    @(posedge clk);
    #1;
    instr_op = op;
    mem_addr = a;
    mem_rdata = m;
    imm_data = m ^ 8'ha5;
    bit_sel = b;
    table_word = {m, ~m};
    wdt_clear_ok = ok;
    instr_valid = 1'b1;
    wait_sig(0, 1'b1);
    instr_valid = 1'b0;
    wait_sig(0, 1'b0);
  endtask : run

  task automatic halt_wake();
    @(posedge clk);
    #1;
    instr_op = OP_HALT;
    instr_valid = 1'b1;
    wait_sig(1, 1'b1);
    instr_valid = 1'b0;
    e_pd = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("halted", 32'h1, 32'(halted));
    chk("power_down_flag", 32'h1, 32'(power_down_flag));
    chk("watchdog_timeout_flag", 32'h0, 32'(watchdog_timeout_flag));
    wake_up = 1'b1;
    wait_sig(1, 1'b0);
    wake_up = 1'b0;
    wait_sig(0, 1'b0);
  endtask : halt_wake

  // monitor: measures busy length, gathers pulses, compares at busy fall
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      if (bprev !== 1'b1) begin
        cnt = 32'h0000_0000;
        pul = 9'h000;
        wcap = 8'h00;
      end
      cnt++;
    end
    pul = pul | {skip_next, stall_req, mem_we, table_last_page, wdt_reset, 4'h0};
    if (mem_we === 1'b1) wcap = mem_wdata;
    if (busy !== 1'b1 && bprev === 1'b1 && q.size() > 0) begin
      mn = q.pop_front();
      chk("cycles", mn.len, cnt);
      fl = pul | {5'h00, zero_flag, carry_flag, power_down_flag, watchdog_timeout_flag};
      chk("flags", 32'(mn.flg), 32'(fl));
      chk("mem_wdata", 32'(mn.wd), 32'(wcap));
      chk("working_register", 32'(mn.wrk), 32'(working_register));
      chk("table_high_byte", 32'(mn.th), 32'(table_high_byte));
    end
    bprev = busy;
  end

  initial begin
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    for (int i = 0; i < 40; i++) begin
      seed = lfsr_next(seed);
      run(opcode_t'(i), 8'h40, seed, seed[2:0], 1'b1);
    end
    $display("test all_ops done");
    foreach (pl[i]) begin
      seed = lfsr_next(seed);
      run(pl[i], PC_LOW_ADDR, seed, seed[5:3], 1'b0);
    end
    run(OP_INC_SKZ, PC_LOW_ADDR, 8'hff, 3'h0, 1'b0);
    run(OP_DEC_SKZ, PC_LOW_ADDR, 8'h01, 3'h0, 1'b0);
    run(OP_SDZA, PC_LOW_ADDR, 8'h01, 3'h0, 1'b0);
    run(OP_SZ, 8'h40, 8'h00, 3'h0, 1'b0);
    run(OP_SKZ_MOVE, 8'h40, 8'h00, 3'h0, 1'b0);
    $display("test pcl_and_skip done");
    for (int b = 0; b < 8; b++) begin
      run(OP_SZB, 8'h40, 8'h01 << b, 3'(b), 1'b0);
      run(OP_SNZB, 8'h40, 8'h01 << b, 3'(b), 1'b0);
      run(OP_SZB, 8'h40, ~(8'h01 << b), 3'(b), 1'b0);
    end
    $display("test bit_skip done");
    halt_wake();
    run(OP_WDT_PRE1, 8'h40, 8'h11, 3'h0, 1'b0);
    run(OP_WDT_PRE2, 8'h40, 8'h22, 3'h0, 1'b1);
    halt_wake();
    run(OP_WDT_CLR, 8'h40, 8'h33, 3'h0, 1'b0);
    $display("test watchdog_halt done");
    // let the monitor compare the last instruction before the verdict
    repeat (2) @(posedge clk);
    #1;
    if (q.size() != 0) begin
      err_count++;
      $display("unexpected pending_notes: expected 0 seen %0d", q.size());
    end
    stop_test();
  end
endmodule : mcu_instruction_timing_tb_top
`default_nettype wire
